// [shared/icp_cfg.svh]
// Constants for the instruction-cycle pipeline: widths, reset values, phase counts
// Behaviour
// - Divide the clock input by four into four non-overlapping phases, first to fourth.
// - Increment the program counter in the first phase of every instruction cycle.
// - Read the word at the program counter and capture it by phase four.
// - Fetch the next instruction while the current one executes: one per cycle.
// - Every instruction other than a branch takes one cycle; a branch takes two cycles.
// - Fetched word sits in the instruction register from phase one; executes two to four.
// - Read the data operand in phase two, write the result in phase four.
// - Instruction words are 12 bits; each of the 33 instructions is one word.
// - A taken branch discards the fetched word and fetches the new target.
`ifndef ICP_CFG_SVH
`define ICP_CFG_SVH
`define ICP_WORD_W 12
`define ICP_INSTR_COUNT 33
`define ICP_PC_W 11
`define ICP_PC_RESET 11'h000
`define ICP_WORD_RESET 12'h000
`define ICP_PHASES 4
`define ICP_PC_STEP 11'h001
`endif

// [shared/icp_pkg.sv]
// Types shared by the instruction-cycle pipeline modules
`include "icp_cfg.svh"
package icp_pkg;
  typedef enum logic [1:0] {
    ICP_PH_ONE = 2'b00,
    ICP_PH_TWO = 2'b01,
    ICP_PH_THREE = 2'b10,
    ICP_PH_FOUR = 2'b11
  } icp_phase_t;
  typedef logic [`ICP_WORD_W-1:0] icp_word_t;
  typedef logic [`ICP_PC_W-1:0] icp_pc_t;
endpackage

// [shared/icp_phase_if.sv]
// Phase sequence carried from the phase generator to the pipeline
`timescale 1ns/100ps
`default_nettype none
interface icp_phase_if;
  import icp_pkg::*;
  icp_phase_t phase;
  logic tick;
  logic running;
  modport gen (output phase, output tick, output running);
  modport use_side (input phase, input tick, input running);
endinterface
`default_nettype wire

// [src/icp_phase_gen.sv]
// Four-phase generator stepped by edges of the external clock input
`timescale 1ns/100ps
`default_nettype none
module icp_phase_gen (
  input wire logic clock,
  input wire logic rst,
  input wire logic external_clock_input,
  icp_phase_if.gen ph
);
  import icp_pkg::*;

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic rise;
  icp_phase_t next_phase;

  // Two stages before use; the pin is asynchronous to clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= external_clock_input;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Each rising input edge steps one phase, so four edges make one cycle
  assign rise = sync_b & ~sync_c;
  assign next_phase = (ph.running) ? icp_phase_t'(ph.phase + 2'b01) : ICP_PH_ONE;
  assign ph.tick = rise;

  // Held in phase four until the first edge so the first tick opens phase one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph.phase <= ICP_PH_FOUR;
      ph.running <= 1'b0;
    end else if (rise) begin
      ph.phase <= next_phase;
      ph.running <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  phase_step_a: assert property (ph.tick && ph.running |=>
    ph.phase == icp_phase_t'($past(ph.phase) + 2'b01))
    else $error("phase did not advance by one");
  phase_hold_a: assert property (!ph.tick |=> $stable(ph.phase))
    else $error("phase moved without an input edge");
endmodule // icp_phase_gen
`default_nettype wire

// [src/icp_pipeline.sv]
// Two-stage fetch and execute pipeline timed by the four instruction phases
`timescale 1ns/100ps
`default_nettype none
`include "icp_cfg.svh"
module icp_pipeline (
  input wire logic clock,
  input wire logic rst,
  input wire logic external_clock_input,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  output icp_pkg::icp_pc_t program_counter,
  output icp_pkg::icp_pc_t prog_addr,
  input wire icp_pkg::icp_word_t prog_data,
  output logic prog_capture,
  output icp_pkg::icp_word_t exec_word,
  output logic exec_valid,
  output logic decode_strobe,
  output logic data_read,
  output logic data_write,
  input wire logic write_req,
  input wire logic branch_req,
  input wire icp_pkg::icp_pc_t branch_target,
  output logic branch_taken
);
  import icp_pkg::*;

  icp_phase_if ph ();

  icp_phase_gen u_phase_gen (
    .clock(clock),
    .rst(rst),
    .external_clock_input(external_clock_input),
    .ph(ph.gen)
  );

  // Phase entry pulses, one clock wide as phases one, two and four open (none for phase three)
  logic enter_one;
  logic enter_two;
  logic enter_four;
  logic in_one;
  logic in_two;
  logic in_three;
  logic in_four;
  icp_word_t fetch_word;
  logic fetch_valid;
  icp_pc_t next_pc;
  icp_pc_t next_prog_addr;
  logic next_fetch_valid;

  // Phases are levels that never overlap; all low before the first edge
  assign in_one = ph.running && (ph.phase == ICP_PH_ONE);
  assign in_two = ph.running && (ph.phase == ICP_PH_TWO);
  assign in_three = ph.running && (ph.phase == ICP_PH_THREE);
  assign in_four = ph.running && (ph.phase == ICP_PH_FOUR);
  assign phase_one = in_one;
  assign phase_two = in_two;
  assign phase_three = in_three;
  assign phase_four = in_four;

  // Actions happen on the tick that opens a phase, not the whole phase
  assign enter_one = ph.tick && (!ph.running || ph.phase == ICP_PH_FOUR);
  assign enter_two = ph.tick && ph.running && (ph.phase == ICP_PH_ONE);
  assign enter_four = ph.tick && ph.running && (ph.phase == ICP_PH_THREE);

  // Branch resolves at the end of its execution cycle, in phase four, with no result write
  assign branch_taken = enter_four && exec_valid && branch_req;

  // Memory strobes only for an instruction that really executes
  assign decode_strobe = enter_two && exec_valid;
  assign data_read = enter_two && exec_valid;
  assign data_write = enter_four && exec_valid && write_req && !branch_req;

  // The word on prog_data is taken as phase four opens
  assign prog_capture = enter_four;

  // Counter steps on phase one; a branch overrides the step and loads target
  assign next_pc = branch_taken ? branch_target :
                   enter_one ? icp_pc_t'(program_counter + `ICP_PC_STEP) :
                   program_counter;
  assign next_prog_addr = enter_one ? program_counter : prog_addr;

  // A word fetched in the same cycle as a taken branch is wrong-path
  assign next_fetch_valid = enter_four ? !branch_taken :
                            enter_one ? 1'b0 :
                            fetch_valid;

  // Program counter and the fetch address it drove last phase one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      program_counter <= `ICP_PC_RESET;
      prog_addr <= `ICP_PC_RESET;
    end else begin
      program_counter <= next_pc;
      prog_addr <= next_prog_addr;
    end
  end

  // Fetch latch: 12-bit word held until the next phase one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fetch_word <= `ICP_WORD_RESET;
      fetch_valid <= 1'b0;
    end else begin
      fetch_valid <= next_fetch_valid;
      if (enter_four) begin
        fetch_word <= prog_data;
      end
    end
  end

  // Instruction register: takes the fetched word while the next fetch starts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exec_word <= `ICP_WORD_RESET;
      exec_valid <= 1'b0;
    end else if (enter_one) begin
      exec_word <= fetch_word;
      exec_valid <= fetch_valid;
    end
  end

  // Checks below compare what this module drives against its inputs and the phase state
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  phase_exclusive_a: assert property ($onehot0({in_one, in_two, in_three, in_four}))
    else $error("phases overlap");

  pc_step_a: assert property (enter_one && !branch_taken |=>
    program_counter == icp_pc_t'($past(program_counter) + `ICP_PC_STEP))
    else $error("counter did not step in phase one");

  fetch_capture_a: assert property (enter_four |=>
    fetch_word == $past(prog_data))
    else $error("fetched word not captured in phase four");

  ir_load_a: assert property (enter_one ##1 (!ph.tick)[*1] |->
    exec_word == $past(fetch_word, 2) && exec_valid == $past(fetch_valid, 2))
    else $error("instruction register not loaded in phase one");

  overlap_a: assert property (enter_one && fetch_valid |=> exec_valid)
    else $error("valid fetch did not reach execution");

  // Strobe must be followed by the matching phase level, not just decode it
  read_slot_a: assert property (data_read |=> in_two && !in_one)
    else $error("operand read outside phase two entry");

  write_slot_a: assert property (data_write |=> in_four && !in_three)
    else $error("result write outside phase four entry");

  branch_flush_a: assert property (branch_taken |=>
    !fetch_valid && program_counter == $past(branch_target))
    else $error("branch did not flush and load target");

  branch_bubble_a: assert property (enter_one && !fetch_valid |=> !exec_valid)
    else $error("flushed slot executed");

  first_exec_a: assert property (!ph.running |-> !exec_valid && !fetch_valid)
    else $error("pipeline valid before the first cycle");

  branch_seen_c: cover property (branch_taken);
  write_seen_c: cover property (data_write ##[1:40] data_read);
  back_to_back_c: cover property (enter_one && exec_valid && fetch_valid);
endmodule // icp_pipeline
`default_nettype wire

// [verif/icp_prog_mem.sv]
// Program memory model answering each fetch address with its word
`timescale 1ns/100ps
`default_nettype none
module icp_prog_mem (
  input wire icp_pkg::icp_pc_t prog_addr,
  output wire icp_pkg::icp_word_t prog_data
);
  import icp_pkg::*;
  // Whole word per address, distinct per location so a wrong fetch shows
  assign prog_data = {prog_addr, 1'b0} ^ 12'ha5c;
endmodule // icp_prog_mem
`default_nettype wire

// [verif/instruction_cycle_pipeline_test.sv]
// Self-checking bench for the instruction-cycle pipeline
`timescale 1ns/100ps
`default_nettype none
module instruction_cycle_pipeline_test;
  import icp_pkg::*;
  logic clock, rst, pin, wr, br, p1, p2, p3, p4, cap, ev_d, dec, rd, dw, bt, ev, k, first, newin;
  icp_pc_t pc, addr, tgt, pc_m, fa;
  icp_word_t data, ew_d, ew, c_rd, c_dec, c_wr, c_bt, c_cap;
  int bad_count, n_compared, div;
  logic [1:0] ph_m;
  logic [3:0] pv, last;
  icp_pipeline dut_u (.clock(clock), .rst(rst), .external_clock_input(pin), .phase_one(p1),
    .phase_two(p2), .phase_three(p3), .phase_four(p4), .program_counter(pc),
    .prog_addr(addr), .prog_data(data), .prog_capture(cap), .exec_word(ew_d),
    .exec_valid(ev_d), .decode_strobe(dec), .data_read(rd), .data_write(dw),
    .write_req(wr), .branch_req(br), .branch_target(tgt), .branch_taken(bt));
  icp_prog_mem mem_u (.prog_addr(addr), .prog_data(data));
  assign pv = {p4, p3, p2, p1};
  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Model state after any reset: nothing fetched yet
  task automatic model_reset;
    pc_m = '0; ev = 1'b0; ph_m = 2'h0; first = 1'b1; last = 4'h0;
    {c_rd, c_dec, c_wr, c_bt, c_cap} = '0;
  endtask
  // Phase one closes the previous cycle and opens a fetch
  task automatic enter_one;
    if (!first) begin
      chk("capture", c_cap, 1);
      chk("read", c_rd, ev);
      chk("decode", c_dec, ev);
      chk("write", c_wr, ev && wr && !br);
      chk("branch", c_bt, ev && br);
      k = ev && br;
      ev = !k;
      ew = {fa, 1'b0} ^ 12'ha5c;
      if (k) pc_m = tgt;
    end
    first = 1'b0;
    {c_rd, c_dec, c_wr, c_bt, c_cap} = '0;
    fa = pc_m;
    chk("fetch_addr", addr, fa);
    pc_m = pc_m + 11'h001;
    chk("counter", pc, pc_m);
    newin = 1'b1;
  endtask
  // One clock: drive just after the edge, check once settled
  task automatic step;
    @(posedge clock);
    #1;
    div = (div + 1) % 6;
    pin = (div < 3);
    if (newin) begin
      wr = 1'($urandom_range(1));
      br = ($urandom_range(3) == 0);
      tgt = 11'($urandom_range(2047));
      newin = 1'b0;
    end
    #4;
    chk("onehot", 12'($onehot0(pv)), 1);
    c_rd += rd;
    c_dec += dec;
    c_wr += dw;
    c_bt += bt;
    c_cap += cap;
    if (pv != last && pv != 4'h0) begin
      chk("phase", pv, 12'h1 << ph_m);
      ph_m = ph_m + 2'h1;
      if (p1) enter_one();
      if (p2) begin
        chk("exec_valid", ev_d, ev);
        if (ev) chk("exec_word", ew_d, ew);
      end
    end
    last = pv;
  endtask
  // Main sequence: run, reset mid-cycle, run again
  initial begin
    void'($urandom(11880));
    {rst, pin, wr, br, newin} = 5'h10;
    tgt = '0;
    div = 0;
    bad_count = 0;
    n_compared = 0;
    model_reset();
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    repeat (7000) step();
    $display("test pipeline run done");
    @(posedge clock);
    #1 rst = 1'b1;
    #4;
    chk("reset_phase", pv, 0);
    chk("reset_valid", ev_d, 0);
    model_reset();
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    repeat (7000) step();
    $display("test mid-run reset done");
    stop_test();
  end
  // Watchdog beyond the expected run length
  initial begin
    #300000;
    bad_count++;
    stop_test();
  end
endmodule // instruction_cycle_pipeline_test
`default_nettype wire
